/* hw/pme_pkg.sv */
// Constants, types and register map of the power management event pin logic
// ****************************************************************************
// What this block does
// - Optionally block resume events while battery low is asserted.
// - Battery, cover, ring, alert pins work as inputs; clock stops as outputs.
// - Drive active-low processor clock stop output to the clock generator.
// - Enabled falling edge on external management input raises management interrupt.
// - Pull the open-drain external management line low on serial interrupt request.
// - Detect both cover switch edges; enabled, each raises management interrupt.
// - Cover switch and power button pass a 16 ms debounce filter.
// - Drive active-low bus clock stop output to the clock generator.
// - Power button is an external event source for power management.
// - Ring indicate is an external wake event source.
// - Suspend well reset clears the suspend well logic.
// - Enabled alert input raises interrupt, management interrupt or resume event.
// ****************************************************************************
package pme_pkg;

  // ****************************************************************************
  // Register byte offsets
  // ****************************************************************************
  localparam logic [7:0] PME_OFS_CTRL = 8'h00;
  localparam logic [7:0] PME_OFS_EVT_EN = 8'h04;
  localparam logic [7:0] PME_OFS_STATUS = 8'h08;
  localparam logic [7:0] PME_OFS_MASK = 8'h0c;
  localparam logic [7:0] PME_OFS_SMI_SEL = 8'h10;
  localparam logic [7:0] PME_OFS_WAKE_EN = 8'h14;
  localparam logic [7:0] PME_OFS_PINS = 8'h18;

  // ****************************************************************************
  // Event bit positions, shared by status, enable, mask, select and wake
  // ****************************************************************************
  localparam int PME_NUM_EVT = 6;
  localparam int PME_EVT_EXTREQ = 0;
  localparam int PME_EVT_COVER = 1;
  localparam int PME_EVT_BUTTON = 2;
  localparam int PME_EVT_RING = 3;
  localparam int PME_EVT_ALERT = 4;
  localparam int PME_EVT_BUSREQ = 5;

  // ****************************************************************************
  // Reset values
  // ****************************************************************************
  localparam logic [10:0] PME_CTRL_RST = 11'h000;
  localparam logic [5:0] PME_EVT_EN_RST = 6'h00;
  localparam logic [5:0] PME_MASK_RST = 6'h00;
  localparam logic [5:0] PME_SMI_SEL_RST = 6'h03;
  localparam logic [5:0] PME_WAKE_EN_RST = 6'h00;
  localparam logic [9:0] PME_SYNC_RST = 10'h3fb;

  // ****************************************************************************
  // Timing
  // ****************************************************************************
  localparam int unsigned PME_CLK_HZ = 100_000_000;
  localparam int unsigned PME_DEB_TIME_MS = 16;
  localparam int unsigned PME_DEB_CYCLES = PME_DEB_TIME_MS * (PME_CLK_HZ / 1000);
  localparam int unsigned PME_BLANK_CYCLES = 4;

  // ****************************************************************************
  // Types
  // ****************************************************************************
  typedef struct packed {
    logic gp_output_18;
    logic gp_output_17;
    logic bus_stop_req;
    logic proc_stop_req;
    logic pin18_mode;
    logic pin17_mode;
    logic alert_gpi_mode;
    logic ring_gpi_mode;
    logic cover_gpi_mode;
    logic lowbat_gpi_mode;
    logic lowbat_block;
  } pme_ctrl_t;

  typedef struct packed {
    logic [3:0] bus_request_monitor_n;
    logic smb_alert_n;
    logic ring_wake_n;
    logic power_button_n;
    logic cover_switch;
    logic ext_mgmt_irq_n;
    logic battery_low_n;
  } pme_pins_t;

endpackage

/* hw/pme_debounce.sv */
// Debounce filter for one synchronised input
`timescale 1ns/1ns
`default_nettype none
module pme_debounce
  import pme_pkg::*;
#(
  parameter int unsigned CYCLES = PME_DEB_CYCLES,
  parameter bit RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic dout_r;

  // ****************************************************************************
  // Level must stay changed for the whole window
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      dout_r <= RST_VAL;
    end else if (din == dout_r) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      dout_r <= din;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign dout = dout_r;
endmodule
`default_nettype wire

/* hw/pme_event_inputs.sv */
// Power management event pins, clock stop controls and their APB registers
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pme_event_inputs
  import pme_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = PME_DEB_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic suspend_well_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic battery_low_n,
  input wire logic ext_mgmt_irq_in,
  output logic ext_mgmt_irq_out,
  output logic ext_mgmt_irq_oe,
  input wire logic cover_switch,
  input wire logic power_button_n,
  input wire logic ring_wake_n,
  input wire logic smb_alert_n,
  input wire logic [3:0] bus_request_monitor_n,
  input wire logic serial_irq_smi,
  output logic sys_mgmt_irq_n,
  output logic irq,
  output logic resume_event,
  output logic proc_clock_stop_n,
  output logic bus_clock_stop_n
);

  // ****************************************************************************
  // Declarations
  // ****************************************************************************
  pme_pins_t pins_raw;
  pme_pins_t pins_s1_r;
  pme_pins_t pins_s2_r;
  pme_ctrl_t ctrl_r;
  logic [PME_NUM_EVT-1:0] evt_en_r;
  logic [PME_NUM_EVT-1:0] status_r;
  logic [PME_NUM_EVT-1:0] status_nxt;
  logic [PME_NUM_EVT-1:0] mask_r;
  logic [PME_NUM_EVT-1:0] smi_sel_r;
  logic [PME_NUM_EVT-1:0] wake_en_r;
  logic [PME_NUM_EVT-1:0] evt_raw;
  logic [PME_NUM_EVT-1:0] evt_set;
  logic [31:0] rdata_nxt;
  logic cover_deb;
  logic button_deb;
  logic cover_prev_r;
  logic button_prev_r;
  logic extreq_prev_r;
  logic ring_prev_r;
  logic alert_prev_r;
  logic [3:0] req_prev_r;
  logic [2:0] blank_cnt_r;
  logic drive_ext_r;
  logic blank;
  logic lowbat_active;
  logic resume_block;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [PME_NUM_EVT-1:0] w1c;
  logic irq_r;
  logic smi_n_r;
  logic resume_r;
  logic proc_stop_n_r;
  logic bus_stop_n_r;

  localparam logic [2:0] BLANK_LOAD = 3'(PME_BLANK_CYCLES);

  // ****************************************************************************
  // Input synchronisers
  // ****************************************************************************
  assign pins_raw = '{
    bus_request_monitor_n: bus_request_monitor_n,
    smb_alert_n: smb_alert_n,
    ring_wake_n: ring_wake_n,
    power_button_n: power_button_n,
    cover_switch: cover_switch,
    ext_mgmt_irq_n: ext_mgmt_irq_in,
    battery_low_n: battery_low_n
  };

  for (genvar i = 0; i < $bits(pme_pins_t); i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pins_s1_r[i] <= PME_SYNC_RST[i];
        pins_s2_r[i] <= PME_SYNC_RST[i];
      end else begin
        pins_s1_r[i] <= pins_raw[i];
        pins_s2_r[i] <= pins_s1_r[i];
      end
    end
  end

  // ****************************************************************************
  // Debounce of cover switch and power button
  // ****************************************************************************
  pme_debounce #(
    .CYCLES(DEBOUNCE_CYCLES),
    .RST_VAL(PME_SYNC_RST[2])
  ) u_cover_deb (
    .clk(clk),
    .rst_b(rst_b),
    .din(pins_s2_r.cover_switch),
    .dout(cover_deb)
  );

  pme_debounce #(
    .CYCLES(DEBOUNCE_CYCLES),
    .RST_VAL(PME_SYNC_RST[3])
  ) u_button_deb (
    .clk(clk),
    .rst_b(rst_b),
    .din(pins_s2_r.power_button_n),
    .dout(button_deb)
  );

  // ****************************************************************************
  // Previous levels for edge detection
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cover_prev_r <= PME_SYNC_RST[2];
      button_prev_r <= PME_SYNC_RST[3];
      extreq_prev_r <= 1'b1;
      ring_prev_r <= 1'b1;
      alert_prev_r <= 1'b1;
      req_prev_r <= 4'hf;
    end else begin
      cover_prev_r <= cover_deb;
      button_prev_r <= button_deb;
      extreq_prev_r <= pins_s2_r.ext_mgmt_irq_n;
      ring_prev_r <= pins_s2_r.ring_wake_n;
      alert_prev_r <= pins_s2_r.smb_alert_n;
      req_prev_r <= pins_s2_r.bus_request_monitor_n;
    end
  end

  // ****************************************************************************
  // Own drive of the external management line
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_ext_r <= 1'b0;
    end else begin
      drive_ext_r <= serial_irq_smi;
    end
  end

  // Ignore our own pull-down until it has left the synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blank_cnt_r <= 3'h0;
    end else if (drive_ext_r) begin
      blank_cnt_r <= BLANK_LOAD;
    end else if (blank_cnt_r != 3'h0) begin
      blank_cnt_r <= blank_cnt_r - 3'h1;
    end
  end

  assign blank = drive_ext_r || (blank_cnt_r != 3'h0);
  assign ext_mgmt_irq_out = 1'b0;
  assign ext_mgmt_irq_oe = drive_ext_r;

  // ****************************************************************************
  // Event detection
  // ****************************************************************************
  always_comb begin
    evt_raw = '0;
    evt_raw[PME_EVT_EXTREQ] = extreq_prev_r && !pins_s2_r.ext_mgmt_irq_n && !blank;
    evt_raw[PME_EVT_COVER] = (cover_prev_r != cover_deb) && !ctrl_r.cover_gpi_mode;
    evt_raw[PME_EVT_BUTTON] = button_prev_r && !button_deb;
    evt_raw[PME_EVT_RING] = ring_prev_r && !pins_s2_r.ring_wake_n && !ctrl_r.ring_gpi_mode;
    evt_raw[PME_EVT_ALERT] = alert_prev_r && !pins_s2_r.smb_alert_n
                             && !ctrl_r.alert_gpi_mode;
    evt_raw[PME_EVT_BUSREQ] = |(req_prev_r & ~pins_s2_r.bus_request_monitor_n);
  end

  assign evt_set = evt_raw & evt_en_r;

  // ****************************************************************************
  // APB decode
  // ****************************************************************************
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    addr_ok = 1'b0;
    if (paddr == PME_OFS_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_EVT_EN) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_MASK) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_SMI_SEL) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_WAKE_EN) begin
      addr_ok = 1'b1;
    end else if (paddr == PME_OFS_PINS) begin
      addr_ok = !pwrite;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ****************************************************************************
  // Control and configuration registers
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= PME_CTRL_RST;
    end else if (wr_en && paddr == PME_OFS_CTRL) begin
      ctrl_r <= pwdata[$bits(pme_ctrl_t)-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_en_r <= PME_EVT_EN_RST;
    end else if (wr_en && paddr == PME_OFS_EVT_EN) begin
      evt_en_r <= pwdata[PME_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= PME_MASK_RST;
    end else if (wr_en && paddr == PME_OFS_MASK) begin
      mask_r <= pwdata[PME_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      smi_sel_r <= PME_SMI_SEL_RST;
    end else if (wr_en && paddr == PME_OFS_SMI_SEL) begin
      smi_sel_r <= pwdata[PME_NUM_EVT-1:0];
    end
  end

  // Wake enables live in the suspend well
  always_ff @(posedge clk or negedge suspend_well_reset_n) begin
    if (!suspend_well_reset_n) begin
      wake_en_r <= PME_WAKE_EN_RST;
    end else if (wr_en && paddr == PME_OFS_WAKE_EN) begin
      wake_en_r <= pwdata[PME_NUM_EVT-1:0];
    end
  end

  // ****************************************************************************
  // Sticky status, write one to clear, set wins
  // ****************************************************************************
  assign w1c = (wr_en && paddr == PME_OFS_STATUS) ? pwdata[PME_NUM_EVT-1:0] : '0;
  assign status_nxt = (status_r & ~w1c) | evt_set;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ****************************************************************************
  // Interrupt, management interrupt and resume outputs
  // ****************************************************************************
  assign lowbat_active = !pins_s2_r.battery_low_n && !ctrl_r.lowbat_gpi_mode;
  assign resume_block = ctrl_r.lowbat_block && lowbat_active;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      smi_n_r <= 1'b1;
      resume_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r & ~smi_sel_r);
      smi_n_r <= !(|(status_nxt & smi_sel_r));
      resume_r <= |(evt_set & wake_en_r) && !resume_block;
    end
  end

  assign irq = irq_r;
  assign sys_mgmt_irq_n = smi_n_r;
  assign resume_event = resume_r;

  // ****************************************************************************
  // Clock stop outputs or general-purpose outputs
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_stop_n_r <= 1'b1;
      bus_stop_n_r <= 1'b1;
    end else begin
      proc_stop_n_r <= ctrl_r.pin17_mode ? ctrl_r.gp_output_17 : !ctrl_r.proc_stop_req;
      bus_stop_n_r <= ctrl_r.pin18_mode ? ctrl_r.gp_output_18 : !ctrl_r.bus_stop_req;
    end
  end

  assign proc_clock_stop_n = proc_stop_n_r;
  assign bus_clock_stop_n = bus_stop_n_r;

  // ****************************************************************************
  // Read data
  // ****************************************************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr == PME_OFS_CTRL) begin
      rdata_nxt[$bits(pme_ctrl_t)-1:0] = ctrl_r;
    end else if (paddr == PME_OFS_EVT_EN) begin
      rdata_nxt[PME_NUM_EVT-1:0] = evt_en_r;
    end else if (paddr == PME_OFS_STATUS) begin
      rdata_nxt[PME_NUM_EVT-1:0] = status_r;
    end else if (paddr == PME_OFS_MASK) begin
      rdata_nxt[PME_NUM_EVT-1:0] = mask_r;
    end else if (paddr == PME_OFS_SMI_SEL) begin
      rdata_nxt[PME_NUM_EVT-1:0] = smi_sel_r;
    end else if (paddr == PME_OFS_WAKE_EN) begin
      rdata_nxt[PME_NUM_EVT-1:0] = wake_en_r;
    end else if (paddr == PME_OFS_PINS) begin
      rdata_nxt[$bits(pme_pins_t)-1:0] = pins_s2_r;
      rdata_nxt[10] = cover_deb;
      rdata_nxt[11] = button_deb;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

/* bench/pme_event_inputs_properties.sv */
// Port-level checker for the power management event pins
`timescale 1ns/1ns
`default_nettype none
module pme_event_inputs_properties
  import pme_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = PME_DEB_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic battery_low_n,
  input wire logic ext_mgmt_irq_in,
  input wire logic ext_mgmt_irq_out,
  input wire logic ext_mgmt_irq_oe,
  input wire logic serial_irq_smi,
  input wire logic sys_mgmt_irq_n,
  input wire logic resume_event,
  input wire logic proc_clock_stop_n,
  input wire logic bus_clock_stop_n
);
  // ********
  // Shadow of written control bits
  // ********
  logic wr_ok;
  logic ext_en_r;
  logic ext_sel_r;
  logic [1:0] bat_ctl_r;
  logic [2:0] hi_cnt_r;
  assign wr_ok = psel && penable && pwrite && pready;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_en_r <= PME_EVT_EN_RST[PME_EVT_EXTREQ];
      ext_sel_r <= PME_SMI_SEL_RST[PME_EVT_EXTREQ];
      bat_ctl_r <= PME_CTRL_RST[1:0];
    end else if (wr_ok) begin
      if (paddr == PME_OFS_EVT_EN) ext_en_r <= pwdata[PME_EVT_EXTREQ];
      if (paddr == PME_OFS_SMI_SEL) ext_sel_r <= pwdata[PME_EVT_EXTREQ];
      if (paddr == PME_OFS_CTRL) bat_ctl_r <= pwdata[1:0];
    end
  end
  // Cycles the external line has stayed released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hi_cnt_r <= 3'h0;
    else if (!ext_mgmt_irq_in || ext_mgmt_irq_oe) hi_cnt_r <= 3'h0;
    else if (hi_cnt_r != 3'h7) hi_cnt_r <= hi_cnt_r + 3'h1;
  end
  // ********
  // Properties
  // ********
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_NO_WAIT: assert property (pready)
    else $error("pready low");
  AST_SMI_EDGE: assert property ($fell(ext_mgmt_irq_in) && !ext_mgmt_irq_oe
      && hi_cnt_r >= 3'h6 && ext_en_r && ext_sel_r |-> ##[1:6] !sys_mgmt_irq_n)
    else $error("external request raised no management interrupt");
  AST_SERIAL_PULL: assert property ($rose(serial_irq_smi) |=> ext_mgmt_irq_oe)
    else $error("serial request did not pull the line");
  AST_OUT_LOW: assert property (ext_mgmt_irq_oe |-> !ext_mgmt_irq_out)
    else $error("line driven high");
  AST_SLVERR: assert property (psel && penable
      && (paddr > PME_OFS_PINS || (pwrite && paddr == PME_OFS_PINS)) |-> pslverr)
    else $error("bad access not refused");
  AST_PROC_STOP: assert property (wr_ok && paddr == PME_OFS_CTRL |-> ##2
      proc_clock_stop_n == ($past(pwdata[5], 2) ? $past(pwdata[9], 2) : !$past(pwdata[7], 2)))
    else $error("processor clock stop wrong");
  AST_BUS_STOP: assert property (wr_ok && paddr == PME_OFS_CTRL |-> ##2
      bus_clock_stop_n == ($past(pwdata[6], 2) ? $past(pwdata[10], 2) : !$past(pwdata[8], 2)))
    else $error("bus clock stop wrong");
  AST_BATTERY_LOW_N: assert property ((bat_ctl_r == 2'b01 && !battery_low_n) [*6] |-> !resume_event)
    else $error("resume while battery low");
endmodule
bind pme_event_inputs pme_event_inputs_properties #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk_u (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .battery_low_n(battery_low_n), .ext_mgmt_irq_in(ext_mgmt_irq_in),
  .ext_mgmt_irq_out(ext_mgmt_irq_out), .ext_mgmt_irq_oe(ext_mgmt_irq_oe),
  .serial_irq_smi(serial_irq_smi), .sys_mgmt_irq_n(sys_mgmt_irq_n),
  .resume_event(resume_event), .proc_clock_stop_n(proc_clock_stop_n),
  .bus_clock_stop_n(bus_clock_stop_n)
);
`default_nettype wire

/* bench/pme_ext_requester.sv */
// Model of the external management requester and the pulled-up line
`timescale 1ns/1ns
`default_nettype none
module pme_ext_requester (
  input wire logic clk,
  input wire logic fire,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic line
);
  logic low_r = 1'b0;
  logic [2:0] gap_r = 3'h7;
  // One cycle low per request, then released at least four cycles
  always @(posedge clk) begin
    low_r <= fire && !low_r && gap_r >= 3'h4;
    gap_r <= low_r ? 3'h0 : ((gap_r == 3'h7) ? gap_r : gap_r + 3'h1);
  end
  // Open-drain line with pull-up
  assign line = (low_r || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* bench/pme_event_inputs_test.sv */
// Self-checking bench for the power management event pins
`timescale 1ns/1ns
`default_nettype none
module pme_event_inputs_test import pme_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic swell_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, serial_irq_smi = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, rd_e, ext_line, ext_out, ext_oe, smi_n, irq, resume_event;
  logic battery_low_n = 1'b1, cover_switch = 1'b0, power_button_n = 1'b1;
  logic ring_wake_n = 1'b1, smb_alert_n = 1'b1, proc_n, bus_n;
  logic [3:0] req_n = 4'hf;
  int failures = 0, tests_run = 0, wake_cnt = 0, base;
  always #5 clk = ~clk;
  always @(posedge clk) if (resume_event === 1'b1) wake_cnt <= wake_cnt + 1;
  pme_event_inputs #(.DEBOUNCE_CYCLES(8)) dut_u (
    .clk(clk), .rst_b(rst_b), .suspend_well_reset_n(swell_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .battery_low_n(battery_low_n),
    .ext_mgmt_irq_in(ext_line), .ext_mgmt_irq_out(ext_out), .ext_mgmt_irq_oe(ext_oe),
    .cover_switch(cover_switch), .power_button_n(power_button_n), .ring_wake_n(ring_wake_n),
    .smb_alert_n(smb_alert_n), .bus_request_monitor_n(req_n), .serial_irq_smi(serial_irq_smi),
    .sys_mgmt_irq_n(smi_n), .irq(irq), .resume_event(resume_event),
    .proc_clock_stop_n(proc_n), .bus_clock_stop_n(bus_n)
  );
  pme_ext_requester req_u (
    .clk(clk), .fire(fire), .dev_out(ext_out), .dev_oe(ext_oe), .line(ext_line)
  );
  // ********
  // Shared tasks
  // ********
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pin(input int k, input logic v);
    case (k)
      2: power_button_n <= v;
      3: ring_wake_n <= v;
      4: smb_alert_n <= v;
      default: req_n[0] <= v;
    endcase
  endtask
  task automatic event_pulse(input int k);
    pin(k, 1'b0);
    cyc(20);
    pin(k, 1'b1);
    cyc(20);
  endtask
  task automatic fire_req();
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    for (int i = 0; i < 12 && smi_n !== 1'b0; i++) cyc(1);
    cyc(6);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    logic [7:0] ofs [5] = '{PME_OFS_CTRL, PME_OFS_EVT_EN, PME_OFS_MASK, PME_OFS_SMI_SEL,
      PME_OFS_WAKE_EN};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      check("reset value", rd_q, (ofs[i] == PME_OFS_SMI_SEL) ? 32'(PME_SMI_SEL_RST) : 32'h0);
    end
    apb(1'b1, PME_OFS_EVT_EN, 32'hffff_ffff);
    apb(1'b0, PME_OFS_EVT_EN, 32'h0);
    check("enable width", rd_q, 32'h3f);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped", {rd_q[30:0], rd_e}, 32'h1);
    apb(1'b1, PME_OFS_PINS, 32'h0);
    check("pins write", {31'h0, rd_e}, 32'h1);
    check("stops idle", {30'h0, proc_n, bus_n}, 32'h3);
  endtask
  task automatic t_stop();
    logic [31:0] v [4] = '{32'h080, 32'h100, 32'h060, 32'h660};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PME_OFS_CTRL, v[i]);
      cyc(1);
      check("proc stop", {31'h0, proc_n}, {31'h0, (v[i][5] ? v[i][9] : !v[i][7])});
      check("bus stop", {31'h0, bus_n}, {31'h0, (v[i][6] ? v[i][10] : !v[i][8])});
    end
    apb(1'b1, PME_OFS_CTRL, 32'h0);
  endtask
  task automatic t_ext();
    apb(1'b1, PME_OFS_EVT_EN, 32'h0);
    fire_req();
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("ext disabled", rd_q, 32'h0);
    apb(1'b1, PME_OFS_EVT_EN, 32'h1);
    fire_req();
    check("ext smi", {31'h0, smi_n}, 32'h0);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("ext status", rd_q, 32'h1);
    apb(1'b1, PME_OFS_STATUS, 32'h1);
    cyc(2);
    check("smi cleared", {31'h0, smi_n}, 32'h1);
    serial_irq_smi <= 1'b1;
    cyc(8);
    check("line pulled", {30'h0, ext_oe, ext_line}, 32'h2);
    serial_irq_smi <= 1'b0;
    cyc(8);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("own pull", rd_q, 32'h0);
  endtask
  task automatic t_cover();
    apb(1'b1, PME_OFS_EVT_EN, 32'h2);
    cover_switch <= 1'b1;
    cyc(3);
    cover_switch <= 1'b0;
    cyc(20);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("cover glitch", rd_q, 32'h0);
    cover_switch <= 1'b1;
    cyc(5);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("cover early", rd_q, 32'h0);
    cyc(15);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("cover rise", {rd_q[30:0], smi_n}, 32'h4);
    apb(1'b1, PME_OFS_STATUS, 32'h2);
    cover_switch <= 1'b0;
    cyc(20);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("cover fall", rd_q, 32'h2);
    apb(1'b1, PME_OFS_STATUS, 32'h2);
  endtask
  task automatic t_events();
    int k [4] = '{2, 3, 4, 5};
    apb(1'b1, PME_OFS_SMI_SEL, 32'h0);
    apb(1'b1, PME_OFS_EVT_EN, 32'h3c);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PME_OFS_MASK, 32'h0);
      event_pulse(k[i]);
      apb(1'b0, PME_OFS_STATUS, 32'h0);
      check("event status", rd_q, 32'h1 << k[i]);
      check("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, PME_OFS_MASK, 32'h1 << k[i]);
      cyc(2);
      check("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, PME_OFS_STATUS, 32'h1 << k[i]);
      cyc(2);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
  endtask
  task automatic t_wake();
    logic [31:0] c [3] = '{32'h0, 32'h1, 32'h3};
    apb(1'b1, PME_OFS_WAKE_EN, 32'h8);
    battery_low_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, PME_OFS_CTRL, c[i]);
      base = wake_cnt;
      event_pulse(3);
      check("wake pulses", 32'(wake_cnt - base), (i == 1) ? 32'h0 : 32'h1);
      apb(1'b1, PME_OFS_STATUS, 32'h3f);
    end
    apb(1'b1, PME_OFS_CTRL, 32'h18);
    pin(3, 1'b0);
    pin(4, 1'b0);
    cyc(5);
    apb(1'b0, PME_OFS_PINS, 32'h0);
    check("pins low", rd_q & 32'h31, 32'h0);
    pin(3, 1'b1);
    pin(4, 1'b1);
    cyc(5);
    apb(1'b0, PME_OFS_STATUS, 32'h0);
    check("ring as input", rd_q, 32'h0);
    battery_low_n <= 1'b1;
    swell_rst_n <= 1'b0;
    cyc(2);
    swell_rst_n <= 1'b1;
    cyc(1);
    apb(1'b0, PME_OFS_WAKE_EN, 32'h0);
    check("wake reset", rd_q, 32'h0);
    apb(1'b0, PME_OFS_EVT_EN, 32'h0);
    check("enable kept", rd_q, 32'h3c);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    swell_rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_stop();
    t_ext();
    t_cover();
    t_events();
    t_wake();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
